// [src/scc_clock_control.sv]
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - Monitor enabled and crystal stuck: system clock falls back to the RC.
// - Fallback persists until reset or software clears the stuck flag.
// - Monitor enable keeps the RC running regardless of its enable bit.
// - Bypass bit writable only while crystal enable and power-up are both zero.
// - Crystal enable cannot clear while used; standby clears it; stable flag reports.
// - Factory calibration loads at power-on; trim is adjust plus calibration.
// - Privilege bit: unprivileged reads see only this bit, writes ignored; clear needs privilege.
// - With security on and unit secure, only secure privileged writes the bit.
// - RC enable cannot clear while used; hardware sets it on wake or stuck.
// - Post divider codes give divide by 2, 4, 6, 8; write only PLL off.
// - PLL source: zero picks RC, one picks crystal.
// - Multiplier writable PLL off, word or half-word only; below 64 reserved.
// - Input prescaler divides by 2 to 63, writable PLL off.
// - Output B source: system, audio PLL, crystal, digital PLL.
// - Output dividers: 0xx by one, 100 to 111 by 2 to 5.
// - Output A source: RC, slow crystal, crystal, PLL post-divided.
// - RTC divider zero gives no clock, n divides crystal by n plus one.
// - Bus two prescaler 2 to 16; bus one 4 to 16 for 101 to 111.
// - System bus prescaler 0xxx passes, 1000 to 1111 divide up to 512.
// - Switch status shows the source actually driving the system clock.
// - Switch select forced to RC on wake or crystal failure in use.
// - Writing one to the stuck clear bit resets the stuck flag.
module scc_clock_control
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [7:0] rc_factory_calibration,
  input wire logic security_ext_enable,
  input wire logic unit_secure,
  input wire logic standby_enter,
  input wire logic lowpower_exit,
  input wire logic fast_crystal_osc_pin,
  input wire logic crystal_ready_pin,
  input wire logic pll_lock_pin,
  input wire logic digital_pll_ready_pin,
  input wire logic rc_ready_pin,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic rc_osc_on,
  output logic [12:0] rc_trim,
  output logic crystal_osc_on,
  output logic crystal_bypass,
  output logic pll_on,
  output logic [31:0] pll_config,
  output logic [31:0] clock_config_zero,
  output logic [1:0] sysclk_mux,
  output logic sysclk_gate
);
  logic [2:0] rdy_s0, rdy_s1, rdy_s2;
  logic xtal_rdy, pll_rdy, dig_rdy;
  logic rc_rdy;
  logic stuck_now, crystal_stuck_flag;
  logic crystal_monitor_enable, crystal_bypass_select, crystal_enable, crystal_power_up;
  logic rc_enable, unit_privilege_protect, pll_enable;
  logic [4:0] rc_trim_adjust;
  logic [7:0] cal;
  logic have_aw, have_w, wr_go, rd_go;
  logic [7:0] aw_addr;
  logic [2:0] aw_prot;
  logic [31:0] wdat;
  logic [3:0] wstb;
  logic wr_priv, wr_sec, rd_priv, wr_full_half, ctl_ok;
  logic [31:0] ctl_view, stat_view, rd_word;
  logic [1:0] target, active;
  logic xtal_in_use, rc_in_use, target_ready;
  scc_sw_state_t sw_state;
  logic [1:0] gap_cnt;
  logic [1:0] pending;
  logic [31:0] next_pll, next_cfg0;

  scc_stuck_monitor u_mon (
    .clk(clk),
    .rst(rst),
    .enable(crystal_monitor_enable && crystal_enable),
    .xtal_clk_pin(fast_crystal_osc_pin),
    .stuck(stuck_now)
  );

  // Ready pins are asynchronous to clk
  always_ff @(posedge clk) begin
    if (rst) begin
      rdy_s0 <= 3'h0;
      rdy_s1 <= 3'h0;
      rdy_s2 <= 3'h0;
      xtal_rdy <= 1'b0;
      pll_rdy <= 1'b0;
      dig_rdy <= 1'b0;
      rc_rdy <= 1'b0;
    end else begin
      rdy_s0 <= {digital_pll_ready_pin, pll_lock_pin, crystal_ready_pin};
      rdy_s1 <= rdy_s0;
      rdy_s2 <= rdy_s1;
      if (rdy_s1[0] == rdy_s2[0]) xtal_rdy <= rdy_s2[0] & crystal_enable;
      if (rdy_s1[1] == rdy_s2[1]) pll_rdy <= rdy_s2[1] & pll_enable;
      if (rdy_s1[2] == rdy_s2[2]) dig_rdy <= rdy_s2[2];
      rc_rdy <= rc_ready_pin & rc_osc_on;
    end
  end

  // Calibration caught on power-on only, not by system reset
  always_ff @(posedge clk) begin
    if (por) cal <= RC_FACTORY_CAL_DEFAULT;
    else if (cal == RC_FACTORY_CAL_DEFAULT) cal <= rc_factory_calibration;
  end

  assign wr_go = have_aw && have_w && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_priv = aw_prot[0];
  assign wr_sec = !aw_prot[1];
  assign rd_priv = s_axi_arprot[0];
  assign wr_full_half = (wstb == 4'hF) || (wstb == 4'h3) || (wstb == 4'hC);
  assign ctl_ok = wr_priv || !unit_privilege_protect;
  assign xtal_in_use = (active == SCC_SRC_XTAL) || (active == SCC_SRC_PLL && pll_config[15]);
  assign rc_in_use = (active == SCC_SRC_RC) || (active == SCC_SRC_PLL && !pll_config[15]);

  // AXI write channel capture
  always_ff @(posedge clk) begin
    if (rst) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      aw_addr <= 8'h00;
      aw_prot <= 3'h0;
      wdat <= 32'h0;
      wstb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        aw_addr <= s_axi_awaddr[7:0];
        aw_prot <= s_axi_awprot;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        wdat <= s_axi_wdata;
        wstb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr <= STAT_OFFSET && aw_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
        have_aw <= 1'b0;
        have_w <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Main control register bits
  always_ff @(posedge clk) begin
    if (rst) begin
      crystal_monitor_enable <= 1'b0;
      crystal_bypass_select <= 1'b1;
      crystal_enable <= 1'b0;
      crystal_power_up <= 1'b0;
      rc_enable <= 1'b1;
      rc_trim_adjust <= RC_TRIM_ADJUST_RESET;
      pll_enable <= 1'b0;
    end else begin
      if (wr_go && aw_addr == CTL_OFFSET && ctl_ok) begin
        if (wstb[2]) begin
          crystal_monitor_enable <= wdat[CTL_MON_EN_BIT];
          if (!crystal_enable && !crystal_power_up) crystal_bypass_select <= wdat[CTL_BYPASS_BIT];
          if (wdat[CTL_XTAL_EN_BIT] || !xtal_in_use) crystal_enable <= wdat[CTL_XTAL_EN_BIT];
        end
        if (wstb[3]) begin
          crystal_power_up <= wdat[CTL_PU_BIT];
          if (wdat[CTL_PLL_EN_BIT] || active != SCC_SRC_PLL) pll_enable <= wdat[CTL_PLL_EN_BIT];
        end
        if (wstb[0]) begin
          rc_trim_adjust <= wdat[7:3];
          if (wdat[CTL_RC_EN_BIT] || !rc_in_use) rc_enable <= wdat[CTL_RC_EN_BIT];
        end
      end
      if (standby_enter) begin
        crystal_enable <= 1'b0;
        crystal_power_up <= 1'b0;
        pll_enable <= 1'b0;
      end
      if (lowpower_exit || (stuck_now && crystal_monitor_enable)) rc_enable <= 1'b1;
    end
  end

  // Privilege bit has its own write permissions
  always_ff @(posedge clk) begin
    if (rst) begin
      unit_privilege_protect <= 1'b0;
    end else if (wr_go && aw_addr == CTL_OFFSET && wstb[0] && wr_priv) begin
      if (!(security_ext_enable && unit_secure) || wr_sec) begin
        unit_privilege_protect <= wdat[CTL_PRIV_BIT];
      end
    end
  end

  // Stuck flag: set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (rst) begin
      crystal_stuck_flag <= 1'b0;
    end else if (stuck_now && crystal_monitor_enable) begin
      crystal_stuck_flag <= 1'b1;
    end else if (wr_go && aw_addr == STAT_OFFSET && ctl_ok && wstb[2] && wdat[STAT_CLEAR_BIT]) begin
      crystal_stuck_flag <= 1'b0;
    end
  end

  always_comb begin
    next_pll = pll_config;
    if (wr_go && aw_addr == PLL_OFFSET && ctl_ok) begin
      if (wstb[1]) next_pll[15] = wdat[15];
      if (!pll_enable) begin
        if (wstb[2]) next_pll[17:16] = wdat[17:16];
        if (wstb[0]) next_pll[5:0] = wdat[5:0];
        if (wr_full_half && wstb[1:0] == 2'h3) next_pll[14:6] = wdat[14:6];
      end
    end
    next_pll = next_pll & PLL_WMASK;
  end

  always_comb begin
    next_cfg0 = clock_config_zero;
    if (wr_go && aw_addr == CFG0_OFFSET && ctl_ok) begin
      for (int b = 0; b < 4; b++) begin
        if (wstb[b]) next_cfg0[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    next_cfg0 = (next_cfg0 & CFG0_WMASK) | {28'h0, active, 2'h0};
    if (lowpower_exit || (stuck_now && crystal_monitor_enable && xtal_in_use)) begin
      next_cfg0[1:0] = SCC_SRC_RC;
    end
  end

  // fields decoded by clock tree dividers from these outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_config <= PLL_RESET;
      clock_config_zero <= CFG0_RESET;
    end else begin
      pll_config <= next_pll;
      clock_config_zero <= next_cfg0;
    end
  end

  assign target = crystal_stuck_flag ? SCC_SRC_RC : clock_config_zero[1:0];
  always_comb begin
    case (target)
      SCC_SRC_RC: target_ready = rc_rdy;
      SCC_SRC_XTAL: target_ready = xtal_rdy;
      SCC_SRC_PLL: target_ready = pll_rdy;
      default: target_ready = dig_rdy;
    endcase
  end

  // Break-before-make switch: gate off, change mux, gate on
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_state <= SCC_SW_IDLE;
      active <= SCC_SRC_RC;
      sysclk_mux <= 2'h0;
      sysclk_gate <= 1'b1;
      gap_cnt <= 2'h0;
      pending <= 2'h0;
    end else begin
      case (sw_state)
        SCC_SW_IDLE: begin
          if (target != active && (target_ready || (stuck_now && crystal_monitor_enable))) begin
            sysclk_gate <= 1'b0;
            // Latched so a late select change cannot pick an unready source
            pending <= target;
            gap_cnt <= 2'(SWITCH_CYCLES);
            sw_state <= SCC_SW_WAIT;
          end
        end
        SCC_SW_WAIT: begin
          if (gap_cnt == 2'h0) begin
            sysclk_mux <= pending;
            gap_cnt <= 2'(SWITCH_CYCLES);
            sw_state <= SCC_SW_GAP;
          end else begin
            gap_cnt <= gap_cnt - 2'h1;
          end
        end
        default: begin
          if (gap_cnt == 2'h0) begin
            sysclk_gate <= 1'b1;
            active <= sysclk_mux;
            sw_state <= SCC_SW_IDLE;
          end else begin
            gap_cnt <= gap_cnt - 2'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rc_osc_on <= 1'b1;
      rc_trim <= 13'h0;
      crystal_osc_on <= 1'b0;
      crystal_bypass <= 1'b0;
      pll_on <= 1'b0;
    end else begin
      rc_osc_on <= rc_enable || crystal_monitor_enable;
      rc_trim <= {5'h0, cal} + {8'h0, rc_trim_adjust};
      crystal_osc_on <= crystal_enable;
      crystal_bypass <= !crystal_bypass_select;
      pll_on <= pll_enable;
    end
  end

  always_comb begin
    ctl_view = 32'h0;
    ctl_view[CTL_PU_BIT] = crystal_power_up;
    ctl_view[CTL_PLL_STB_BIT] = pll_rdy;
    ctl_view[CTL_PLL_EN_BIT] = pll_enable;
    ctl_view[CTL_MON_EN_BIT] = crystal_monitor_enable;
    ctl_view[CTL_BYPASS_BIT] = crystal_bypass_select;
    ctl_view[CTL_STABLE_BIT] = xtal_rdy;
    ctl_view[CTL_XTAL_EN_BIT] = crystal_enable;
    ctl_view[15:8] = cal;
    ctl_view[7:3] = rc_trim_adjust;
    ctl_view[CTL_PRIV_BIT] = unit_privilege_protect;
    ctl_view[CTL_RC_STB_BIT] = rc_rdy;
    ctl_view[CTL_RC_EN_BIT] = rc_enable;
    stat_view = 32'h0;
    stat_view[STAT_STUCK_BIT] = crystal_stuck_flag;
  end

  always_comb begin
    rd_word = 32'h0;
    if (s_axi_araddr[7:0] == CTL_OFFSET) rd_word = ctl_view;
    else if (s_axi_araddr[7:0] == PLL_OFFSET) rd_word = pll_config;
    else if (s_axi_araddr[7:0] == CFG0_OFFSET) rd_word = clock_config_zero;
    else if (s_axi_araddr[7:0] == STAT_OFFSET) rd_word = stat_view;
    if (unit_privilege_protect && !rd_priv) begin
      rd_word = (s_axi_araddr[7:0] == CTL_OFFSET) ? (ctl_view & 32'h00000004) : 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (s_axi_araddr[7:0] <= STAT_OFFSET && s_axi_araddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// [src/scc_pkg.sv]
package scc_pkg;
  localparam logic [7:0] CTL_OFFSET = 8'h00;
  localparam logic [7:0] PLL_OFFSET = 8'h04;
  localparam logic [7:0] CFG0_OFFSET = 8'h08;
  localparam logic [7:0] STAT_OFFSET = 8'h0C;
  localparam logic [31:0] PLL_RESET = 32'h00003010;
  localparam logic [31:0] CFG0_RESET = 32'h00009400;
  localparam logic [4:0] RC_TRIM_ADJUST_RESET = 5'h10;
  localparam logic [7:0] RC_FACTORY_CAL_DEFAULT = 8'h80;
  localparam int CTL_MON_EN_BIT = 19;
  localparam int CTL_BYPASS_BIT = 18;
  localparam int CTL_STABLE_BIT = 17;
  localparam int CTL_XTAL_EN_BIT = 16;
  localparam int CTL_PU_BIT = 28;
  localparam int CTL_PLL_EN_BIT = 24;
  localparam int CTL_PLL_STB_BIT = 25;
  localparam int CTL_PRIV_BIT = 2;
  localparam int CTL_RC_STB_BIT = 1;
  localparam int CTL_RC_EN_BIT = 0;
  localparam int STAT_STUCK_BIT = 7;
  localparam int STAT_CLEAR_BIT = 23;
  localparam logic [31:0] PLL_WMASK = 32'h0003FFFF;
  localparam logic [31:0] CFG0_WMASK = 32'hFF7FFCF3;
  localparam int STUCK_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int STUCK_CYCLES = STUCK_TIME_NS / CLK_PERIOD_NS;
  localparam int SWITCH_TIME_NS = 300;
  localparam int SWITCH_CYCLES = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {SCC_SRC_RC, SCC_SRC_XTAL, SCC_SRC_PLL, SCC_SRC_DIG} scc_src_t;
  typedef enum logic [1:0] {SCC_SW_IDLE, SCC_SW_WAIT, SCC_SW_GAP} scc_sw_state_t;
endpackage

// [src/scc_stuck_monitor.sv]
`timescale 1ns/1ps
module scc_stuck_monitor
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic xtal_clk_pin,
  output logic stuck
);
  logic [2:0] sync;
  logic [4:0] quiet;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync <= 3'h0;
    end else begin
      sync <= {sync[1:0], xtal_clk_pin};
    end
  end
  // Stuck low or high both look like no edge for the whole window
  always_ff @(posedge clk) begin
    if (rst || !enable || (sync[1] != sync[2])) begin
      quiet <= 5'h00;
      stuck <= 1'b0;
    end else if (quiet == 5'(STUCK_CYCLES - 1)) begin
      stuck <= 1'b1;
    end else begin
      quiet <= quiet + 5'h01;
    end
  end
endmodule

// [verif/scc_clock_control_asserts.sv]
`timescale 1ns/1ps
module scc_clock_control_asserts
  import scc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic lowpower_exit,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic rc_osc_on,
  input wire logic crystal_osc_on,
  input wire logic crystal_bypass,
  input wire logic pll_on,
  input wire logic [31:0] pll_config,
  input wire logic [31:0] clock_config_zero,
  input wire logic [1:0] sysclk_mux,
  input wire logic sysclk_gate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_mux_gate_off: assert property ($changed(sysclk_mux) |-> !sysclk_gate)
    else $error("mux moved with gate open");
  a_gate_low_min: assert property ($fell(sysclk_gate) |-> !sysclk_gate [*3])
    else $error("gate reopened too soon");
  a_gate_low_max: assert property ($fell(sysclk_gate) |-> ##[1:20] sysclk_gate)
    else $error("gate stayed closed");
  a_status_follow: assert property (sysclk_gate [*3] |-> clock_config_zero[3:2] == sysclk_mux)
    else $error("status differs from mux");
  a_wake_select: assert property (lowpower_exit |-> ##[1:3] clock_config_zero[1:0] == 2'b00)
    else $error("select not forced on wake");
  a_wake_rc_on: assert property (lowpower_exit |-> ##[1:3] rc_osc_on)
    else $error("rc not on after wake");
  a_rc_in_use: assert property (sysclk_gate && sysclk_mux == SCC_SRC_RC |-> rc_osc_on)
    else $error("rc off while driving");
  a_xtal_in_use: assert property (sysclk_mux == SCC_SRC_XTAL |-> crystal_osc_on)
    else $error("crystal off while driving");
  a_bypass_lock: assert property ($changed(crystal_bypass) |-> !$past(crystal_osc_on))
    else $error("bypass moved with crystal on");
  a_pll_frozen: assert property (pll_on |=> $stable(pll_config[17:16]) && $stable(pll_config[14:0]))
    else $error("pll fields moved while on");
  c_switch: cover property ($fell(sysclk_gate));
  c_wake: cover property (lowpower_exit);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_on_xtal: cover property (sysclk_mux == SCC_SRC_XTAL);
endmodule
bind scc_clock_control scc_clock_control_asserts u_chk (.*);

// [verif/scc_clock_control_tb_top.sv]
`timescale 1ns/1ps
module scc_clock_control_tb_top
  import scc_pkg::*;
;
  logic clk = 0, rst = 1, por = 1, security_ext_enable = 0, unit_secure = 0, standby_enter = 0;
  logic lowpower_exit = 0, fast_crystal_osc_pin = 0, crystal_ready_pin = 0, pll_lock_pin = 0;
  logic digital_pll_ready_pin = 0, rc_ready_pin = 1, xt_run = 0;
  logic [7:0] rc_factory_calibration = 8'h5A;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0, s_axi_rdata, rd_d;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, wr_r, rd_r, sysclk_mux;
  logic rc_osc_on, crystal_osc_on, crystal_bypass, pll_on, sysclk_gate;
  logic [12:0] rc_trim;
  logic [31:0] pll_config, clock_config_zero;
  int n_fail = 0, samples_checked = 0, cyc = 0;
  scc_clock_control dut (.*);
  initial begin
    forever #50 clk = ~clk;
  end
  // Free-running crystal; stopping it models a stuck oscillator
  always @(posedge clk) if (xt_run) fast_crystal_osc_pin <= ~fast_crystal_osc_pin;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      end_sim;
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [2:0] p = 3'b001);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= {24'h000000, a};
    s_axi_awprot <= p;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awready) aw = 1;
      if (s_axi_wready) w = 1;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    wr_r = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [2:0] p = 3'b001);
    s_axi_araddr <= {24'h000000, a};
    s_axi_arprot <= p;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge clk); while (!s_axi_rvalid);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
    s_axi_rready <= 0;
    @(posedge clk);
  endtask
  // Polls status; the switch takes several gated cycles
  task automatic wait_ss(input logic [1:0] t);
    for (int i = 0; i < 40; i++) begin
      rd(CFG0_OFFSET);
      if (rd_d[3:2] === t) break;
    end
  endtask
  task automatic t_reset;
    rd(PLL_OFFSET);
    chk(rd_d, PLL_RESET, "pll reset");
    rd(CFG0_OFFSET);
    chk(rd_d, CFG0_RESET, "cfg0 reset");
    rd(CTL_OFFSET);
    chk({rd_d[18], rd_d[15:3], rd_d[0]}, {1'b1, 8'h5A, 5'h10, 1'b1}, "ctl reset");
    chk(rc_trim, 13'h006A, "trim");
    wr(CTL_OFFSET, 32'h0004FFF9);
    repeat (3) @(posedge clk);
    rd(CTL_OFFSET);
    chk(rd_d[15:3], {8'h5A, 5'h1F}, "cal read only");
    chk(rc_trim, 13'h0079, "trim sum");
    $display("t_reset done");
  endtask
  task automatic t_cfg0;
    wr(CFG0_OFFSET, 32'hFFFFFFF0);
    rd(CFG0_OFFSET);
    chk(rd_d, 32'hFF7FFCF0, "cfg0 fields");
    chk(clock_config_zero, 32'hFF7FFCF0, "cfg0 port");
    wr(CFG0_OFFSET, CFG0_RESET);
    $display("t_cfg0 done");
  endtask
  task automatic t_pll;
    wr(PLL_OFFSET, 32'hFFFFFFFF);
    rd(PLL_OFFSET);
    chk(rd_d, 32'h0003FFFF, "pll fields");
    wr(PLL_OFFSET, 32'h0, 4'h2);
    rd(PLL_OFFSET);
    chk(rd_d[14:6], 9'h1FF, "byte write");
    wr(PLL_OFFSET, 32'h00001042, 4'h3);
    rd(PLL_OFFSET);
    chk(rd_d, 32'h00031042, "half write");
    pll_lock_pin <= 1;
    wr(CTL_OFFSET, 32'h0104FFF9);
    repeat (4) @(posedge clk);
    wr(PLL_OFFSET, 32'h00000FFF);
    rd(PLL_OFFSET);
    chk(rd_d, 32'h00031042, "pll locked");
    chk(pll_config, 32'h00031042, "pll port");
    wr(CTL_OFFSET, 32'h0004FFF9);
    $display("t_pll done");
  endtask
  task automatic t_switch;
    wr(CTL_OFFSET, 32'h0000FFF9);
    rd(CTL_OFFSET);
    chk({rd_d[18], crystal_bypass}, 2'b01, "bypass on");
    xt_run <= 1;
    wr(CTL_OFFSET, 32'h1005FFF9);
    wr(CFG0_OFFSET, 32'h00009401);
    repeat (10) @(posedge clk);
    rd(CFG0_OFFSET);
    chk(rd_d[3:2], 2'b00, "waits for ready");
    crystal_ready_pin <= 1;
    wait_ss(2'b01);
    chk(rd_d[3:2], 2'b01, "status xtal");
    chk(sysclk_mux, SCC_SRC_XTAL, "mux xtal");
    wr(CTL_OFFSET, 32'h1000FFF9);
    rd(CTL_OFFSET);
    chk(rd_d[18:16], 3'b111, "xtal locked");
    $display("t_switch done");
  endtask
  task automatic t_stuck;
    wr(CTL_OFFSET, 32'h100DFFF8);
    repeat (3) @(posedge clk);
    chk(rc_osc_on, 1'b1, "monitor keeps rc");
    xt_run <= 0;
    repeat (40) @(posedge clk);
    wait_ss(2'b00);
    chk(rd_d[3:0], 4'h0, "select forced");
    chk(sysclk_mux, SCC_SRC_RC, "fallback");
    rd(STAT_OFFSET);
    chk(rd_d[7], 1'b1, "stuck flag");
    rd(CTL_OFFSET);
    chk(rd_d[0], 1'b1, "rc forced on");
    xt_run <= 1;
    wr(CFG0_OFFSET, 32'h00009401);
    repeat (30) @(posedge clk);
    rd(CFG0_OFFSET);
    chk(rd_d[3:2], 2'b00, "fallback holds");
    wr(STAT_OFFSET, 32'h0);
    rd(STAT_OFFSET);
    chk(rd_d[7], 1'b1, "zero no clear");
    wr(STAT_OFFSET, 32'h00800000);
    rd(STAT_OFFSET);
    chk(rd_d[7], 1'b0, "flag cleared");
    wr(CFG0_OFFSET, 32'h00009401);
    wait_ss(2'b01);
    chk(rd_d[3:2], 2'b01, "xtal back");
    wr(CTL_OFFSET, 32'h1005FFF8);
    repeat (3) @(posedge clk);
    chk(rc_osc_on, 1'b0, "rc off");
    $display("t_stuck done");
  endtask
  task automatic t_lowpower;
    lowpower_exit <= 1;
    @(posedge clk);
    lowpower_exit <= 0;
    wait_ss(2'b00);
    chk(rd_d[1:0], 2'b00, "wake select");
    rd(CTL_OFFSET);
    chk(rd_d[0], 1'b1, "wake rc");
    wr(CTL_OFFSET, 32'h1005FFF8);
    rd(CTL_OFFSET);
    chk(rd_d[0], 1'b1, "rc in use");
    standby_enter <= 1;
    @(posedge clk);
    standby_enter <= 0;
    repeat (3) @(posedge clk);
    rd(CTL_OFFSET);
    chk({rd_d[28], rd_d[16]}, 2'b00, "standby");
    $display("t_lowpower done");
  endtask
  task automatic t_priv;
    wr(CTL_OFFSET, 32'h0004FFFD);
    rd(CTL_OFFSET, 3'b000);
    chk(rd_d, 32'h00000004, "unpriv ctl");
    rd(PLL_OFFSET, 3'b000);
    chk(rd_d, 32'h0, "unpriv pll");
    wr(PLL_OFFSET, 32'h0, 4'hF, 3'b000);
    rd(PLL_OFFSET);
    chk(rd_d, 32'h00031042, "unpriv write");
    wr(CTL_OFFSET, 32'h0004FFF9, 4'hF, 3'b000);
    rd(CTL_OFFSET);
    chk(rd_d[2], 1'b1, "unpriv clear");
    security_ext_enable <= 1;
    unit_secure <= 1;
    wr(CTL_OFFSET, 32'h0004FFF9, 4'hF, 3'b011);
    rd(CTL_OFFSET);
    chk(rd_d[2], 1'b1, "nonsecure clear");
    wr(CTL_OFFSET, 32'h0004FFF9);
    rd(CTL_OFFSET);
    chk(rd_d[2], 1'b0, "secure clear");
    security_ext_enable <= 0;
    unit_secure <= 0;
    $display("t_priv done");
  endtask
  // PLL fed by the crystal drives the system clock
  task automatic t_pllsys;
    wr(PLL_OFFSET, 32'h00008000, 4'h2);
    wr(CTL_OFFSET, 32'h1105FFF9);
    wr(CFG0_OFFSET, 32'h00009402);
    wait_ss(2'b10);
    chk(rd_d[3:2], 2'b10, "status pll");
    wr(CTL_OFFSET, 32'h1000FFF9);
    rd(CTL_OFFSET);
    chk({rd_d[24], rd_d[16]}, 2'b11, "pll xtal locked");
    chk({pll_on, crystal_osc_on}, 2'b11, "osc outputs");
    rd(PLL_OFFSET);
    chk(rd_d[15], 1'b1, "pll source");
    $display("t_pllsys done");
  endtask
  task automatic t_bad;
    rd(8'h10);
    chk(rd_r, 2'b10, "bad read");
    wr(8'h06, 32'h0);
    chk(wr_r, 2'b10, "unaligned write");
    $display("t_bad done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    por <= 0;
    repeat (4) @(posedge clk);
    t_reset;
    t_cfg0;
    t_pll;
    t_switch;
    t_stuck;
    t_lowpower;
    t_priv;
    t_pllsys;
    t_bad;
    end_sim;
  end
endmodule
